// ===== include/pcscsv_pkg.sv
// Package for the PCS configuration and status bundles: field positions, masks, constants
package pcscsv_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Control bundle layout
    localparam int                CTRL_W          = 5;
    localparam int                CTRL_POWER_DOWN = 2;
    localparam int                CTRL_ISOLATE    = 3;
    localparam int                CTRL_AN_ENABLE  = 4;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Advertisement bundle layout
    localparam int                ADV_W           = 16;
    localparam int                ADV_SGMII_ONE   = 0;
    localparam int                ADV_FULL_DUPLEX = 5;
    localparam int                ADV_PAUSE_LO    = 7;
    localparam int                ADV_PAUSE_HI    = 8;
    localparam int                ADV_SPEED_LO    = 10;
    localparam int                ADV_SPEED_HI    = 11;
    localparam int                ADV_RFAULT_LO   = 12;
    localparam int                ADV_RFAULT_HI   = 13;
    localparam int                ADV_SGMII_DUPLX = 12;
    localparam int                ADV_SGMII_ACK   = 14;
    localparam int                ADV_SGMII_LINK  = 15;

    // Bits that carry meaning per standard; all others are dropped
    localparam logic [ADV_W-1:0]  ADV_MASK_BASEX  = 16'h31a0;
    localparam logic [ADV_W-1:0]  ADV_MASK_SGPHY  = 16'hdc01;
    localparam logic [ADV_W-1:0]  ADV_WORD_SGMAC  = 16'h4001;
    localparam logic [ADV_W-1:0]  ADV_WORD_RESET  = 16'h0000;

    // Speed code that the advertisement must never carry; SGMII PHY still passes it through and only raises adv_speed_rsvd
    localparam logic [1:0]        ADV_SPEED_RSVD  = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Operating standard of the advertisement former
    typedef enum logic [1:0] {
        PCSCSV_STD_BASEX,
        PCSCSV_STD_SGMII_PHY,
        PCSCSV_STD_SGMII_MAC
    } pcscsv_std_t;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Indications from the receive path of the PCS
    typedef struct packed {
        logic sync_ok;            // Code-group sync state machine reports OK
        logic autoneg_done;       // Auto-negotiation has completed
        logic xcvr_reset_done;    // Transceiver reset sequence finished
        logic config_set_rx_flag; // Configuration ordered sets being received
    } pcscsv_pcs_ind_t;

    // Status bundle, bit 2 first
    typedef struct packed {
        logic config_rx;          // Bit 2
        logic link_sync;          // Bit 1
        logic link_status;        // Bit 0
    } pcscsv_status_t;

    localparam pcscsv_status_t    STATUS_RESET    = '{config_rx: 1'b0, link_sync: 1'b0,
                                                      link_status: 1'b0};

endpackage : pcscsv_pkg

// ===== verilog/pcscsv_adv_former.sv
// Forms the advertised auto-negotiation word from the user bundle and operating standard
`timescale 1ns/10ps

module pcscsv_adv_former
    import pcscsv_pkg::*;
(
    // Selection
    input  wire pcscsv_std_t      std_sel,
    // User advertisement bundle
    input  wire logic [ADV_W-1:0] advert_control_bus,
    // Formed word and checks
    output logic [ADV_W-1:0]      adv_word_next,
    output logic                  speed_code_rsvd,
    output logic                  sgmii_one_missing
);

    // Reserved bits of the active standard are masked so stray user bits never go out
    always_comb begin
        unique case (std_sel)
            PCSCSV_STD_BASEX: begin
                adv_word_next = advert_control_bus & ADV_MASK_BASEX;
            end
            PCSCSV_STD_SGMII_PHY: begin
                adv_word_next = advert_control_bus & ADV_MASK_SGPHY;
            end
            PCSCSV_STD_SGMII_MAC: begin
                adv_word_next = ADV_WORD_SGMAC;
            end
            default: begin
                adv_word_next = ADV_WORD_SGMAC;
            end
        endcase
    end

    // Checks on the user bundle, meaningful only while it is in use for SGMII PHY
    assign speed_code_rsvd   = (std_sel == PCSCSV_STD_SGMII_PHY) &&
                               (advert_control_bus[ADV_SPEED_HI:ADV_SPEED_LO] == ADV_SPEED_RSVD);
    assign sgmii_one_missing = (std_sel == PCSCSV_STD_SGMII_PHY) &&
                               !advert_control_bus[ADV_SGMII_ONE];

endmodule : pcscsv_adv_former

// ===== verilog/pcscsv_top.sv
// Configuration and status bundle logic of the gigabit PCS: control, advertisement, status
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - control bit 2 latches transceiver power-down until reset; ten-bit variant ignores it.
// - control bit 3 high isolates the client GMII; low gives normal operation.
// - control bit 4 enables auto-negotiation, only if the negotiation module exists.
// - in BASE-X, advertisement bit 5 advertises full duplex.
// - in BASE-X, advertisement bits 8:7 carry the pause capability code.
// - in SGMII, advertisement bits 11:10 carry the speed code.
// - in BASE-X, advertisement bits 13:12 carry the remote fault code.
// - in SGMII, advertisement bit 12 gives duplex; bit 13 reserved.
// - in SGMII, advertisement bit 14 carries the acknowledge flag.
// - in SGMII, advertisement bit 15 reports PHY link up or down.
// - in SGMII MAC mode the advertised word is fixed and the bundle ignored.
// - BASE-X and SGMII PHY load the advertised word from the bundle.
// - status bit 0 high only with sync, negotiation done if enabled, reset done.
// - status bit 0 equals link status with negotiation on, else status bit 1.
// - status bit 1 follows code-group sync once transceiver reset is done, without negotiation qualification.
// - status bit 2 high while configuration ordered sets are being received.
module pcscsv_top
    import pcscsv_pkg::*;
#(
    parameter bit TEN_BIT_VARIANT = 1'b0,
    parameter bit AUTONEG_PRESENT = 1'b1
)
(
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    // Operating standard
    input  wire logic              sgmii_sel,
    input  wire logic              sgmii_phy_side,
    // User configuration bundles
    input  wire logic [CTRL_W-1:0] control_bus,
    input  wire logic [ADV_W-1:0]  advert_control_bus,
    // Indications from the PCS receive path
    input  wire pcscsv_pcs_ind_t   pcs_ind,
    // Controls toward the core
    output logic                   xcvr_power_down,
    output logic                   gmii_isolate,
    output logic                   autoneg_enable,
    output logic [ADV_W-1:0]       autoneg_advert_word,
    // Status toward the user
    output pcscsv_status_t         status_bus,
    output logic                   link_up_pulse,
    output logic                   link_down_pulse,
    output logic                   adv_speed_rsvd,
    output logic                   adv_sgmii_one_low
);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic             power_down_reg;
    logic             isolate_reg;
    logic             autoneg_en_reg;
    logic [ADV_W-1:0] adv_word_reg;
    logic [ADV_W-1:0] adv_word_next;
    logic             speed_rsvd_next;
    logic             one_missing_next;
    logic             speed_rsvd_reg;
    logic             one_missing_reg;
    pcscsv_std_t      std_sel;
    pcscsv_status_t   status_reg;
    pcscsv_status_t   status_next;
    logic             link_ok_next;
    logic             link_up_reg;
    logic             link_down_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Transceiver power-down; only the integrated transceiver has a low-power state to enter
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_down_reg <= 1'b0;
        end else if (!TEN_BIT_VARIANT && control_bus[CTRL_POWER_DOWN]) begin
            power_down_reg <= 1'b1;
        end
    end

    // Clearing the bit again does not wake the transceiver; reset is the only way out
    assign xcvr_power_down = power_down_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // GMII isolation follows the control bit one cycle later
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            isolate_reg <= 1'b0;
        end else begin
            isolate_reg <= control_bus[CTRL_ISOLATE];
        end
    end

    assign gmii_isolate = isolate_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Auto-negotiation enable, tied off when the negotiation module is left out
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            autoneg_en_reg <= 1'b0;
        end else begin
            autoneg_en_reg <= AUTONEG_PRESENT && control_bus[CTRL_AN_ENABLE];
        end
    end

    assign autoneg_enable = autoneg_en_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Standard decode; the MAC side of SGMII takes its word from no bundle at all
    always_comb begin
        if (!sgmii_sel) begin
            std_sel = PCSCSV_STD_BASEX;
        end else if (sgmii_phy_side) begin
            std_sel = PCSCSV_STD_SGMII_PHY;
        end else begin
            std_sel = PCSCSV_STD_SGMII_MAC;
        end
    end

    // Word former
    pcscsv_adv_former u_adv_former (
        .std_sel            (std_sel),
        .advert_control_bus (advert_control_bus),
        .adv_word_next      (adv_word_next),
        .speed_code_rsvd    (speed_rsvd_next),
        .sgmii_one_missing  (one_missing_next)
    );

    // Advertised word register, reloaded every cycle so a standard switch takes effect at the next clock edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            adv_word_reg <= ADV_WORD_RESET;
        end else begin
            adv_word_reg <= adv_word_next;
        end
    end

    assign autoneg_advert_word = adv_word_reg;

    // Flags for bundle values the link partner would misread
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            speed_rsvd_reg  <= 1'b0;
            one_missing_reg <= 1'b0;
        end else begin
            speed_rsvd_reg  <= speed_rsvd_next;
            one_missing_reg <= one_missing_next;
        end
    end

    assign adv_speed_rsvd    = speed_rsvd_reg;
    assign adv_sgmii_one_low = one_missing_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Status: sync is taken as valid only once the transceiver is out of reset, so that
    // bit 0 and bit 1 agree exactly whenever negotiation is off
    always_comb begin
        status_next.link_sync   = pcs_ind.sync_ok && pcs_ind.xcvr_reset_done;
        link_ok_next            = status_next.link_sync &&
                                  (!autoneg_en_reg || pcs_ind.autoneg_done);
        status_next.link_status = link_ok_next;
        status_next.config_rx   = pcs_ind.config_set_rx_flag;
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status_bus = status_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Link change events, one cycle each, aligned with the status bit change
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_up_reg   <= 1'b0;
            link_down_reg <= 1'b0;
        end else begin
            link_up_reg   <= link_ok_next && !status_reg.link_status;
            link_down_reg <= !link_ok_next && status_reg.link_status;
        end
    end

    assign link_up_pulse   = link_up_reg;
    assign link_down_pulse = link_down_reg;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions
    AST_PWR_DOWN_SET: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (control_bus[CTRL_POWER_DOWN] && !TEN_BIT_VARIANT) |=> xcvr_power_down [*3])
        else $error("power-down not entered and held");

    AST_PWR_DOWN_STICKY: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        xcvr_power_down |=> xcvr_power_down)
        else $error("power-down left without reset");

    AST_PWR_DOWN_TBI: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        TEN_BIT_VARIANT |-> !xcvr_power_down)
        else $error("ten-bit variant entered power-down");

    AST_ISOLATE: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        ##1 gmii_isolate == $past(control_bus[CTRL_ISOLATE]))
        else $error("isolate does not follow control bit");

    AST_AN_ENABLE: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(control_bus[CTRL_AN_ENABLE]) |=> (autoneg_enable == AUTONEG_PRESENT))
        else $error("negotiation enable wrong");

    AST_SGMII_MAC_FIXED: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (sgmii_sel && !sgmii_phy_side) |=> (autoneg_advert_word == 16'h4001))
        else $error("MAC side word not fixed");

    AST_BASEX_DUPLEX: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !sgmii_sel |=> autoneg_advert_word[5] == $past(advert_control_bus[5]))
        else $error("full duplex bit not carried");

    AST_BASEX_PAUSE_FAULT: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !sgmii_sel |=> (autoneg_advert_word[8:7] == $past(advert_control_bus[8:7])) &&
                       (autoneg_advert_word[13:12] == $past(advert_control_bus[13:12])))
        else $error("pause or remote fault not carried");

    AST_BASEX_RSVD: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !sgmii_sel |=> (autoneg_advert_word & 16'hce5f) == 16'h0000)
        else $error("reserved bit leaked in BASE-X");

    AST_SGPHY_FIELDS: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (sgmii_sel && sgmii_phy_side) |=>
            (autoneg_advert_word[15:10] == ($past(advert_control_bus[15:10]) & 6'h37)))
        else $error("SGMII link, ack, duplex or speed not carried");

    AST_SGPHY_RSVD: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (sgmii_sel && sgmii_phy_side) |=> (autoneg_advert_word & 16'h23fe) == 16'h0000)
        else $error("reserved bit leaked in SGMII");

    AST_LINK_QUAL: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        status_bus.link_status |-> $past(pcs_ind.sync_ok && pcs_ind.xcvr_reset_done) &&
                                   (!$past(autoneg_en_reg) || $past(pcs_ind.autoneg_done)))
        else $error("link reported without its conditions");

    AST_LINK_NO_AN: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !$past(autoneg_en_reg) |-> status_bus.link_status == status_bus.link_sync)
        else $error("link differs from sync with negotiation off");

    AST_SYNC_FOLLOW: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        (pcs_ind.sync_ok && pcs_ind.xcvr_reset_done) |=> status_bus.link_sync)
        else $error("sync status not reported");

    AST_CONFIG_RX: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        pcs_ind.config_set_rx_flag |=> status_bus.config_rx)
        else $error("configuration reception not reported");

    AST_CONFIG_RX_CLR: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        !pcs_ind.config_set_rx_flag |=> !status_bus.config_rx)
        else $error("configuration reception reported while absent");

    // Event pulses must line up with the status bit edge they announce
    AST_LINK_EVENT: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $rose(status_bus.link_status) |-> link_up_pulse ##1 !link_up_pulse)
        else $error("link up event missing");

    AST_LINK_DOWN_EVENT: assert property (
        @(posedge sys_clk) disable iff (!arst_n)
        $fell(status_bus.link_status) |-> link_down_pulse ##1 !link_down_pulse)
        else $error("link down event missing");

endmodule : pcscsv_top

// ===== test/pcscsv_user_model.sv
// User-side model: client logic that drives the configuration bundles of the PCS
`timescale 1ns/10ps

module pcscsv_user_model
    import pcscsv_pkg::*;
(
    // Mode and requests from the bench
    input  wire logic              sgmii_sel,
    input  wire logic              break_one,
    input  wire logic [CTRL_W-1:0] req_ctrl,
    input  wire logic [ADV_W-1:0]  req_adv,
    // Bundles toward the device
    output logic [CTRL_W-1:0]      control_bus,
    output logic [ADV_W-1:0]       advert_control_bus
);
    ////////////////////////////////////////////////////////////////////////////////////////
    // Bundles follow the request at once, so the bench's falling-edge timing carries through
    assign control_bus = req_ctrl;
    // SGMII wants bit 0 high; break_one lets a scenario drop it on purpose to see the flag
    assign advert_control_bus = req_adv | {15'h0000, sgmii_sel & ~break_one};
endmodule : pcscsv_user_model

// ===== test/testbench.sv
// Self-checking bench for the PCS configuration and status bundle logic
`timescale 1ns/10ps

module testbench
    import pcscsv_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////////////////
    logic              sys_clk, arst_n, sgmii_sel, sgmii_phy_side, break_one;
    logic [CTRL_W-1:0] req_ctrl, control_bus;
    logic [ADV_W-1:0]  req_adv, advert_control_bus, autoneg_advert_word, e_word;
    pcscsv_pcs_ind_t   pcs_ind;
    pcscsv_status_t    status_bus, e_st;
    logic              xcvr_power_down, gmii_isolate, autoneg_enable, link_up_pulse;
    logic              link_down_pulse, adv_speed_rsvd, adv_sgmii_one_low;
    logic              e_pd, e_iso, e_an, e_up, e_dn, e_spd, e_one, lnk, phy;
    logic              t_pd, t_an;
    pcscsv_status_t    t_st;
    logic [31:0]       lfsr;
    int                n_errors, cmp_count, cycles;

    pcscsv_top #(.TEN_BIT_VARIANT(1'b0), .AUTONEG_PRESENT(1'b1)) i_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .sgmii_sel(sgmii_sel),
        .sgmii_phy_side(sgmii_phy_side), .control_bus(control_bus),
        .advert_control_bus(advert_control_bus), .pcs_ind(pcs_ind),
        .xcvr_power_down(xcvr_power_down), .gmii_isolate(gmii_isolate),
        .autoneg_enable(autoneg_enable), .autoneg_advert_word(autoneg_advert_word),
        .status_bus(status_bus), .link_up_pulse(link_up_pulse),
        .link_down_pulse(link_down_pulse), .adv_speed_rsvd(adv_speed_rsvd),
        .adv_sgmii_one_low(adv_sgmii_one_low));

    // Second build: ten-bit variant without the negotiation module, same stimulus
    pcscsv_top #(.TEN_BIT_VARIANT(1'b1), .AUTONEG_PRESENT(1'b0)) i_dut_tbi (
        .sys_clk(sys_clk), .arst_n(arst_n), .sgmii_sel(sgmii_sel),
        .sgmii_phy_side(sgmii_phy_side), .control_bus(control_bus),
        .advert_control_bus(advert_control_bus), .pcs_ind(pcs_ind),
        .xcvr_power_down(t_pd), .gmii_isolate(), .autoneg_enable(t_an),
        .autoneg_advert_word(), .status_bus(t_st), .link_up_pulse(),
        .link_down_pulse(), .adv_speed_rsvd(), .adv_sgmii_one_low());

    pcscsv_user_model i_user (
        .sgmii_sel(sgmii_sel), .break_one(break_one), .req_ctrl(req_ctrl),
        .req_adv(req_adv), .control_bus(control_bus),
        .advert_control_bus(advert_control_bus));

    // 125 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Advertised word built field by field, independent of any mask constant
    function automatic logic [15:0] exp_word(input logic sg, input logic ph,
                                             input logic [15:0] a);
        logic [15:0] w;
        w = 16'h0000;
        if (sg && !ph) begin
            w = 16'h4001;
        end else if (sg) begin
            w[0] = a[0];
            w[12:10] = a[12:10];
            w[15:14] = a[15:14];
        end else begin
            w[5] = a[5];
            w[8:7] = a[8:7];
            w[13:12] = a[13:12];
        end
        return w;
    endfunction : exp_word

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    // Reference model: one-cycle registers; link status uses the previous enable value
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            {e_pd, e_iso, e_an, e_up, e_dn, e_spd, e_one} = 7'h00;
            e_word = 16'h0000;
            e_st = STATUS_RESET;
        end else begin
            lnk = pcs_ind.sync_ok & pcs_ind.xcvr_reset_done & (~e_an | pcs_ind.autoneg_done);
            e_up = lnk & ~e_st.link_status;
            e_dn = ~lnk & e_st.link_status;
            e_st.config_rx = pcs_ind.config_set_rx_flag;
            e_st.link_sync = pcs_ind.sync_ok & pcs_ind.xcvr_reset_done;
            e_st.link_status = lnk;
            e_pd = e_pd | control_bus[CTRL_POWER_DOWN];
            e_iso = control_bus[CTRL_ISOLATE];
            e_an = control_bus[CTRL_AN_ENABLE];
            e_word = exp_word(sgmii_sel, sgmii_phy_side, advert_control_bus);
            phy = sgmii_sel & sgmii_phy_side;
            e_spd = phy & (advert_control_bus[11:10] == 2'h3);
            e_one = phy & ~advert_control_bus[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic cmp_all();
        check("xcvr_power_down", {15'h0000, xcvr_power_down}, {15'h0000, e_pd});
        check("gmii_isolate", {15'h0000, gmii_isolate}, {15'h0000, e_iso});
        check("autoneg_enable", {15'h0000, autoneg_enable}, {15'h0000, e_an});
        check("advert_word", autoneg_advert_word,
              e_word);
        check("link_status", {15'h0000, status_bus.link_status},
              {15'h0000, e_st.link_status});
        check("link_sync", {15'h0000, status_bus.link_sync},
              {15'h0000, e_st.link_sync});
        check("config_rx", {15'h0000, status_bus.config_rx},
              {15'h0000, e_st.config_rx});
        check("link_edges", {14'h0000, link_up_pulse, link_down_pulse},
              {14'h0000, e_up, e_dn});
        check("adv_flags", {14'h0000, adv_speed_rsvd, adv_sgmii_one_low},
              {14'h0000, e_spd, e_one});
        check("tbi_power_down", {15'h0000, t_pd}, 16'h0000);
        check("tbi_autoneg_enable", {15'h0000, t_an}, 16'h0000);
        check("tbi_link_status", {15'h0000, t_st.link_status},
              {15'h0000, e_st.link_sync});
    endtask : cmp_all

    // Check what the last rising edge produced, then drive the next inputs at the falling edge
    task automatic step(input logic [1:0] m, input logic [15:0] adv, input logic [4:0] ctl,
                        input logic [3:0] ind, input logic brk);
        cmp_all();
        sgmii_sel = (m != 2'h0);
        sgmii_phy_side = (m == 2'h1);
        req_adv = adv;
        req_ctrl = ctl;
        pcs_ind = ind;
        break_one = brk;
        @(negedge sys_clk);
    endtask : step

    task automatic end_of_test();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    // Hang guard: the run needs about 3040 cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles >= 10000) begin
            n_errors++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        {n_errors, cmp_count, cycles} = '0;
        lfsr = 32'h8fae;
        {arst_n, sgmii_sel, sgmii_phy_side, break_one} = 4'h0;
        req_ctrl = 5'h00;
        req_adv = 16'h0000;
        pcs_ind = 4'h0;
        repeat (4) @(negedge sys_clk);
        arst_n = 1'b1;
        // Every two-bit code in every field, in each standard; reserved bits set too
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 4; i++) begin
                step(m[1:0], {8{i[1:0]}}, 5'h08, 4'h1, 1'b0);
                step(m[1:0], ~{8{i[1:0]}}, 5'h00, 4'h0, 1'b0);
            end
        end
        // Bit 0 dropped in SGMII PHY, then standard switch back to back
        step(2'h1, 16'hfffe, 5'h00, 4'h0, 1'b1);
        step(2'h2, 16'hffff, 5'h00, 4'h0, 1'b0);
        // Negotiation on: sync alone is not enough; then done; then sync lost
        step(2'h0, 16'h0000, 5'h10, 4'ha, 1'b0);
        step(2'h0, 16'h0000, 5'h10, 4'ha, 1'b0);
        step(2'h0, 16'h0000, 5'h10, 4'he, 1'b0);
        step(2'h0, 16'h0000, 5'h10, 4'h6, 1'b0);
        step(2'h0, 16'h0000, 5'h00, 4'ha, 1'b0);
        step(2'h0, 16'h0000, 5'h00, 4'h2, 1'b0);
        // Power-down pulse latches, low bit does not clear it, reset in mid-run does
        step(2'h0, 16'h0000, 5'h04, 4'ha, 1'b0);
        step(2'h0, 16'h0000, 5'h00, 4'ha, 1'b0);
        step(2'h0, 16'h0000, 5'h00, 4'ha, 1'b0);
        arst_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        cmp_all();
        arst_n = 1'b1;
        step(2'h0, 16'h0000, 5'h00, 4'ha, 1'b0);
        // Random traffic; power-down requested only rarely so other outputs stay visible
        for (int k = 0; k < 3000; k++) begin
            lfsr = lfsr_next(lfsr_next(lfsr_next(lfsr)));
            step((lfsr[17:16] == 2'h3) ? 2'h0 : lfsr[17:16], lfsr[15:0],
                 {lfsr[21:20], (lfsr[31:24] == 8'h00), lfsr[19:18]}, lfsr[26:23],
                 lfsr[27] & lfsr[28]);
        end
        cmp_all();
        end_of_test();
    end
endmodule : testbench
